// ### pkg/tmz_pkg.sv
// Constants and types shared by the timer/counter0 design files
package tmz_pkg;

  // Register offsets on the internal I/O port
  localparam logic [7:0] TMZ_OFS_CONTROL = 8'h33;
  localparam logic [7:0] TMZ_OFS_COUNT = 8'h32;
  localparam logic [7:0] TMZ_OFS_FLAG = 8'h38;
  localparam logic [7:0] TMZ_OFS_MASK = 8'h39;
  localparam logic [7:0] TMZ_OFS_FLAG_CLEAR = 8'h3a;

  // Register widths and field layout
  localparam int unsigned TMZ_DATA_W = 8;
  localparam int unsigned TMZ_ADDR_W = 8;
  localparam int unsigned TMZ_CS_W = 3;
  localparam int unsigned TMZ_OVF_BIT = 1;
  localparam int unsigned TMZ_FLAG_W = 8;

  // Reset values, read-zero value and count constants
  localparam logic [2:0] TMZ_RST_CS = 3'h0;
  localparam logic [7:0] TMZ_RST_COUNT = 8'h00;
  localparam logic [7:0] TMZ_RST_FLAG = 8'h00;
  localparam logic [7:0] TMZ_RST_MASK = 8'h00;
  localparam logic [7:0] TMZ_READ_ZERO = 8'h00;
  localparam logic [7:0] TMZ_COUNT_MAX = 8'hff;
  localparam logic [7:0] TMZ_COUNT_ONE = 8'h01;

  // Shared prescaler: width, number of taps, per-tap low-bit masks
  localparam int unsigned TMZ_PRE_W = 10;
  localparam int unsigned TMZ_NUM_TAPS = 4;
  localparam logic [9:0] TMZ_PRE_RST = 10'h000;
  localparam logic [9:0] TMZ_PRE_ONE = 10'h001;
  // Tap 0: /8, tap 1: /64, tap 2: /256, tap 3: /1024
  localparam logic [9:0] TMZ_TAP_MASK [4] = '{
    10'h007, 10'h03f, 10'h0ff, 10'h3ff
  };
  localparam int unsigned TMZ_TAP_DIV8 = 0;
  localparam int unsigned TMZ_TAP_DIV64 = 1;
  localparam int unsigned TMZ_TAP_DIV256 = 2;
  localparam int unsigned TMZ_TAP_DIV1024 = 3;

  // Clock select encodings of the control register
  typedef enum logic [2:0] {
    TMZ_CS_STOP = 3'h0,
    TMZ_CS_CLK = 3'h1,
    TMZ_CS_DIV8 = 3'h2,
    TMZ_CS_DIV64 = 3'h3,
    TMZ_CS_DIV256 = 3'h4,
    TMZ_CS_DIV1024 = 3'h5,
    TMZ_CS_PIN_FALL = 3'h6,
    TMZ_CS_PIN_RISE = 3'h7
  } tmz_cs_t;

endpackage : tmz_pkg

// ### design/tmz_prescaler.sv
// Shared free-running 10-bit prescaler with four divided tick taps
`timescale 1ns/1ps

module tmz_prescaler
  import tmz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // One-cycle tick per tap: /8, /64, /256, /1024
  output logic [TMZ_NUM_TAPS-1:0] tap_tick
);

  logic [TMZ_PRE_W-1:0] pre_cnt_ff;
  logic [TMZ_PRE_W-1:0] nxt_pre_cnt;
  logic [TMZ_NUM_TAPS-1:0] tick_ff;
  logic [TMZ_NUM_TAPS-1:0] nxt_tick;

  // Counts straight off the system clock, no other source
  assign nxt_pre_cnt = pre_cnt_ff + TMZ_PRE_ONE;

  // One tick per tap when its low bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < TMZ_NUM_TAPS; gi++) begin : g_tap
      assign nxt_tick[gi] =
        ((pre_cnt_ff & TMZ_TAP_MASK[gi]) == TMZ_TAP_MASK[gi]);
    end
  endgenerate

  // Counter and registered ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_ff <= TMZ_PRE_RST;
      tick_ff <= '0;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tap_tick = tick_ff;

endmodule : tmz_prescaler

// ### design/tmz_timer0.sv
// 8-bit timer/counter0 with shared prescaler, pin input and registers
`timescale 1ns/1ps

module tmz_timer0
  import tmz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [TMZ_ADDR_W-1:0] reg_addr,
  input wire logic [TMZ_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [TMZ_DATA_W-1:0] reg_rdata,
  // Pad level of the count pin, seen whatever its direction
  input wire logic external_count_pin,
  // Global interrupt enable from the core status
  input wire logic global_int_en,
  // Interrupt request, level
  output logic irq,
  // Prescaler taps offered to the second timer
  output logic [TMZ_NUM_TAPS-1:0] shared_tap_tick,
  // Overflow event, one cycle
  output logic overflow_pulse
);

  // Prescaler taps
  logic [TMZ_NUM_TAPS-1:0] tap_tick;

  // Control and count state
  logic [TMZ_CS_W-1:0] clock_select_ff;
  logic [TMZ_DATA_W-1:0] count_ff;
  logic [TMZ_DATA_W-1:0] nxt_count;

  // Count pin synchroniser and edge history
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_last_ff;

  // Interrupt flag and mask registers
  logic [TMZ_FLAG_W-1:0] flag_ff;
  logic [TMZ_FLAG_W-1:0] nxt_flag;
  logic [TMZ_FLAG_W-1:0] mask_ff;
  logic irq_ff;
  logic ovf_ff;

  // Read data register
  logic [TMZ_DATA_W-1:0] rdata_ff;
  logic [TMZ_DATA_W-1:0] nxt_rdata;

  // Shared prescaler, also feeding the second timer
  tmz_prescaler u_prescaler (
    .clk (clk),
    .rstn (rstn),
    .tap_tick (tap_tick)
  );

  assign shared_tap_tick = tap_tick;

  // Register address decode
  wire sel_control = (reg_addr == TMZ_OFS_CONTROL);
  wire sel_count = (reg_addr == TMZ_OFS_COUNT);
  wire sel_flag = (reg_addr == TMZ_OFS_FLAG);
  wire sel_mask = (reg_addr == TMZ_OFS_MASK);
  wire sel_clear = (reg_addr == TMZ_OFS_FLAG_CLEAR);

  // Write strobes per register
  wire wr_control = reg_wr && sel_control;
  wire wr_count = reg_wr && sel_count;
  wire wr_mask = reg_wr && sel_mask;
  wire wr_clear = reg_wr && sel_clear;

  // Edge detection on the synchronised pin only
  wire pin_rise = pin_sync_ff && !pin_last_ff;
  wire pin_fall = !pin_sync_ff && pin_last_ff;

  // Clock select as an enumerated mode
  tmz_cs_t cs_mode;
  assign cs_mode = tmz_cs_t'(clock_select_ff);

  // Count enable chosen by the clock select field
  logic count_tick;
  always_comb begin
    count_tick = 1'b0;
    unique case (cs_mode)
      TMZ_CS_STOP: count_tick = 1'b0;
      TMZ_CS_CLK: count_tick = 1'b1;
      TMZ_CS_DIV8: count_tick = tap_tick[TMZ_TAP_DIV8];
      TMZ_CS_DIV64: count_tick = tap_tick[TMZ_TAP_DIV64];
      TMZ_CS_DIV256: count_tick = tap_tick[TMZ_TAP_DIV256];
      TMZ_CS_DIV1024: count_tick = tap_tick[TMZ_TAP_DIV1024];
      TMZ_CS_PIN_FALL: count_tick = pin_fall;
      TMZ_CS_PIN_RISE: count_tick = pin_rise;
    endcase
  end

  // Wrap from all ones to zero, lost when software writes the count
  wire count_wrap = count_tick && (count_ff == TMZ_COUNT_MAX)
                    && !wr_count;

  // Next count: a write wins, else up by one on a tick
  always_comb begin
    nxt_count = count_ff;
    if (wr_count) begin
      nxt_count = reg_wdata;
    end else if (count_tick) begin
      nxt_count = count_ff + TMZ_COUNT_ONE;
    end
  end

  // Sticky flag: hardware set beats a clear in the same cycle
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_clear) begin
      nxt_flag = flag_ff & ~reg_wdata;
    end
    nxt_flag[TMZ_OVF_BIT] = nxt_flag[TMZ_OVF_BIT] || count_wrap;
    // Unused flag positions stay zero
    nxt_flag = nxt_flag & (TMZ_FLAG_W'(1) << TMZ_OVF_BIT);
  end

  // Read data multiplexer; unmapped and write-only read zero
  always_comb begin
    nxt_rdata = TMZ_READ_ZERO;
    if (reg_rd) begin
      if (sel_control) begin
        nxt_rdata = {{(TMZ_DATA_W-TMZ_CS_W){1'b0}},
                     clock_select_ff};
      end else if (sel_count) begin
        nxt_rdata = count_ff;
      end else if (sel_flag) begin
        nxt_rdata = flag_ff;
      end else if (sel_mask) begin
        nxt_rdata = mask_ff;
      end
    end
  end

  // Count pin synchroniser, sampled on rising clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_last_ff <= 1'b0;
    end else begin
      pin_meta_ff <= external_count_pin;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  // Control register: only the clock select field is stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_select_ff <= TMZ_RST_CS;
    end else if (wr_control) begin
      clock_select_ff <= reg_wdata[TMZ_CS_W-1:0];
    end
  end

  // Counter register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= TMZ_RST_COUNT;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Flag and mask registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_ff <= TMZ_RST_FLAG;
      mask_ff <= TMZ_RST_MASK;
    end else begin
      flag_ff <= nxt_flag;
      if (wr_mask) begin
        mask_ff <= reg_wdata & (TMZ_FLAG_W'(1) << TMZ_OVF_BIT);
      end
    end
  end

  // Interrupt, overflow pulse and read data registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
      ovf_ff <= 1'b0;
      rdata_ff <= TMZ_READ_ZERO;
    end else begin
      irq_ff <= global_int_en && |(nxt_flag & mask_ff);
      ovf_ff <= count_wrap;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs
  assign irq = irq_ff;
  assign overflow_pulse = ovf_ff;
  assign reg_rdata = rdata_ff;

endmodule : tmz_timer0

// ### tb/tmz_timer0_assertions.sv
// Port checks for the timer/counter0 block
`timescale 1ns/1ps

module tmz_timer0_assertions
  import tmz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [TMZ_ADDR_W-1:0] reg_addr,
  input wire logic [TMZ_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [TMZ_DATA_W-1:0] reg_rdata,
  // Pin and interrupt
  input wire logic external_count_pin,
  input wire logic global_int_en,
  input wire logic irq,
  // Events
  input wire logic [TMZ_NUM_TAPS-1:0] shared_tap_tick,
  input wire logic overflow_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read data only after a strobe
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  // Upper control bits read zero
  property p_ctl_rsvd;
    reg_rd && reg_addr == TMZ_OFS_CONTROL |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("control upper bits set");
  // Divide-by-8 tick period
  property p_tick8;
    shared_tap_tick[0] |=> !shared_tap_tick[0] [*7] ##1 shared_tap_tick[0];
  endproperty
  a_tick8: assert property (p_tick8)
    else $error("tick8 period");
  // Taps nest on one counter
  property p_tap64;
    shared_tap_tick[1] |-> shared_tap_tick[0];
  endproperty
  a_tap64: assert property (p_tap64)
    else $error("tick64 off tick8");
  property p_tap256;
    shared_tap_tick[2] |-> shared_tap_tick[1];
  endproperty
  a_tap256: assert property (p_tap256)
    else $error("tick256 off tick64");
  property p_tap1024;
    shared_tap_tick[3] |-> shared_tap_tick[2];
  endproperty
  a_tap1024: assert property (p_tap1024)
    else $error("tick1024 off tick256");
  // Overflow event lasts one cycle
  property p_ovf_once;
    overflow_pulse |=> !overflow_pulse;
  endproperty
  a_ovf_once: assert property (p_ovf_once)
    else $error("overflow pulse long");
  // Global enable gates the request
  property p_gie_off;
    !global_int_en |=> !irq;
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("irq without global enable");
endmodule : tmz_timer0_assertions

bind tmz_timer0 tmz_timer0_assertions u_tmz_timer0_assertions (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .external_count_pin(external_count_pin),
  .global_int_en(global_int_en), .irq(irq),
  .shared_tap_tick(shared_tap_tick), .overflow_pulse(overflow_pulse));

// ### tb/tmz_pin_model.sv
// Source of edges on the count pin
`timescale 1ns/1ps

module tmz_pin_model (
  // Clock
  input wire logic clk,
  // Request for three pulses
  input wire logic go,
  // Count pin level
  output logic pin
);
  logic [2:0] left_ff;

  initial begin
    pin = 1'b0;
    left_ff = 3'h0;
  end
  // Six toggles, one clock apart
  always @(posedge clk) begin
    if (go) begin
      left_ff <= 3'h6;
    end else if (left_ff != 3'h0) begin
      pin <= ~pin;
      left_ff <= left_ff - 3'h1;
    end
  end
endmodule : tmz_pin_model

// ### tb/test_tmz_timer0.sv
// Self-checking bench for the timer/counter0 block
`timescale 1ns/1ps

module test_tmz_timer0
  import tmz_pkg::*;
;
  logic clk, rstn, reg_wr, reg_rd, gie, go, pin, irq, ovf;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [3:0] tick;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  tmz_timer0 u_tmz_timer0 (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_count_pin(pin),
    .global_int_en(gie), .irq(irq), .shared_tap_tick(tick),
    .overflow_pulse(ovf));
  tmz_pin_model u_tmz_pin_model (.clk(clk), .go(go), .pin(pin));

  // Compare and tally
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle write
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read, data in the next cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // Test sequence
  initial begin
    {rstn, reg_wr, reg_rd, gie, go} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(TMZ_OFS_CONTROL, v);
    chk("ctl rst", v, 8'h00);
    wr(TMZ_OFS_CONTROL, 8'hff);
    rd(TMZ_OFS_CONTROL, v);
    chk("ctl", v, 8'h07);
    rd(8'h00, v);
    chk("unmapped", v, 8'h00);
    wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_CLK));
    wr(TMZ_OFS_COUNT, 8'h80);
    rd(TMZ_OFS_COUNT, v);
    chk("cnt", v, 8'h80);
    rd(TMZ_OFS_COUNT, v);
    chk("cnt", v, 8'h81);
    wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_STOP));
    wr(TMZ_OFS_COUNT, 8'h55);
    repeat (20) @(posedge clk);
    rd(TMZ_OFS_COUNT, v);
    chk("stop", v, 8'h55);
    // Each divided rate over four periods
    for (int i = 0; i < 4; i++) begin
      wr(TMZ_OFS_COUNT, 8'h00);
      wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_DIV8) + 8'(i));
      repeat (4 * (int'(TMZ_TAP_MASK[i]) + 1)) @(posedge clk);
      wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_STOP));
      rd(TMZ_OFS_COUNT, v);
      chk("div", {7'h0, (v inside {8'h04, 8'h05})}, 8'h01);
    end
    // Falling then rising pin edges
    for (int i = 0; i < 2; i++) begin
      wr(TMZ_OFS_COUNT, 8'h00);
      wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_PIN_FALL) + 8'(i));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk);
      rd(TMZ_OFS_COUNT, v);
      chk("pin", v, 8'h03);
    end
    // Wrap, mask, clear
    gie <= 1'b1;
    wr(TMZ_OFS_COUNT, 8'hfe);
    wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_CLK));
    repeat (4) @(posedge clk);
    #1;
    chk("irq masked", {7'h0, irq}, 8'h00);
    rd(TMZ_OFS_FLAG, v);
    chk("flag", v, 8'h02);
    wr(TMZ_OFS_MASK, 8'h02);
    rd(TMZ_OFS_MASK, v);
    chk("mask", v, 8'h02);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_STOP));
    wr(TMZ_OFS_FLAG_CLEAR, 8'h02);
    rd(TMZ_OFS_FLAG, v);
    chk("flag clr", v, 8'h00);
    chk("irq clr", {7'h0, irq}, 8'h00);
    // Wrap and clear in one cycle: the set must win
    wr(TMZ_OFS_CONTROL, 8'(TMZ_CS_CLK));
    wr(TMZ_OFS_COUNT, 8'hfe);
    wr(TMZ_OFS_MASK, 8'h02);
    wr(TMZ_OFS_FLAG_CLEAR, 8'h02);
    chk("ovf", {7'h0, ovf}, 8'h01);
    chk("irq set", {7'h0, irq}, 8'h01);
    rd(TMZ_OFS_FLAG, v);
    chk("flag set wins", v, 8'h02);
    chk("ovf once", {7'h0, ovf}, 8'h00);
    // Global enable off masks a pending request
    gie <= 1'b0;
    @(posedge clk);
    #1;
    chk("irq gie", {7'h0, irq}, 8'h00);
    print_verdict();
  end
endmodule : test_tmz_timer0
